/* File: include/rdfc_pkg.sv */
// Package for the reference divider and function control block.
// Assumes a single 100 MHz clock and 32-bit serial words whose low three bits select the target register.
`default_nettype none

package rdfc_pkg;

	// Serial word framing and the control codes that select a register.
	localparam int WORD_W = 32;
	localparam int CTRL_W = 3;
	localparam logic [2:0] CTRL_FRACTIONAL_VALUE_INT = 3'h0;
	localparam logic [2:0] CTRL_REF_DIV = 3'h2;
	localparam logic [2:0] CTRL_FUNC = 3'h3;

	// Field positions of the reference divider word.
	localparam int RD_CP_MSB = 27;
	localparam int RD_CP_LSB = 24;
	localparam int RD_PRESC_BIT = 22;
	localparam int RD_HALVE_BIT = 21;
	localparam int RD_DOUBLE_BIT = 20;
	localparam int RD_RCNT_MSB = 19;
	localparam int RD_RCNT_LSB = 15;
	localparam int RD_STEP_MSB = 14;
	localparam int RD_STEP_LSB = 3;

	// Field positions of the function control word.
	localparam int FN_BLEED_MSB = 24;
	localparam int FN_BLEED_LSB = 22;
	localparam int FN_BLEED_EN_BIT = 21;
	localparam int FN_LOL_BIT = 16;
	localparam int FN_NSEL_BIT = 15;
	localparam int FN_SDKEEP_BIT = 14;
	localparam int FN_RAMP_MSB = 11;
	localparam int FN_RAMP_LSB = 10;
	localparam int FN_PSK_BIT = 9;
	localparam int FN_FSK_BIT = 8;
	localparam int FN_LDP_BIT = 7;
	localparam int FN_POL_BIT = 6;
	localparam int FN_PD_BIT = 5;
	localparam int FN_CPTRI_BIT = 4;
	localparam int FN_CRST_BIT = 3;

	// Values after reset.
	localparam logic [31:0] REF_DIV_RESET = 32'h0000_0000;
	localparam logic [31:0] FUNC_RESET = 32'h0000_0000;
	localparam logic [31:0] FRACTIONAL_VALUE_INT_RESET = 32'h0000_0000;

	// Lock detect timing, in ns as printed, and the cycle counts derived from them.
	localparam int CLK_PERIOD_NS = 10;
	localparam int LD_WIDE_NS = 14;
	localparam int LD_FINE_NS = 6;
	localparam int LD_UNLOCK_NS = 22;
	localparam int LD_WIDE_CYC = (LD_WIDE_NS / CLK_PERIOD_NS > 0) ? LD_WIDE_NS / CLK_PERIOD_NS : 1;
	localparam int LD_FINE_CYC = (LD_FINE_NS / CLK_PERIOD_NS > 0) ? LD_FINE_NS / CLK_PERIOD_NS : 1;
	localparam int LD_UNLOCK_CYC = (LD_UNLOCK_NS / CLK_PERIOD_NS > 0) ? LD_UNLOCK_NS / CLK_PERIOD_NS : 1;
	localparam int LD_SAMPLE_EVERY = 32;
	localparam int LD_LOCK_COUNT = 5;
	localparam int LD_REF_LOSS_CYC = 4096;
	localparam int INT_LOAD_DELAY_PFD = 4;

	// Decoded configuration presented to the analog and counter blocks.
	typedef struct packed {
		logic [3:0] pump_current_level;
		logic prescaler_89;
		logic reference_halver_enable;
		logic doubler_en;
		logic [4:0] ref_count;
		logic [11:0] ramp_step_divider;
		logic [2:0] bleed_level;
		logic bleed_en;
		logic loss_lock_mode;
		logic int_load_delay_en;
		logic mod_keep;
		logic [1:0] ramp_mode;
		logic psk_en;
		logic fsk_en;
		logic lock_precision_sel;
		logic detector_polarity;
		logic power_down;
	} rdfc_cfg_t;

endpackage : rdfc_pkg

`default_nettype wire

/* File: hdl/rdfc_ref_counter.sv */
// Reference counter: divides active reference edges by 1 to 32, with an optional halving toggle.
// Assumes edge_en is a one-cycle pulse on clk for every active reference edge.
`default_nettype none

module rdfc_ref_counter (
	input wire logic clk,
	input wire logic rst,
	input wire logic edge_en,
	input wire logic [4:0] ratio_code,
	input wire logic halve,
	input wire logic hold,
	output logic ref_pulse,
	output logic ref_level
);
	import rdfc_pkg::*;

	logic [4:0] count_reg;
	logic [4:0] count_next;

	// Code zero stands for a ratio of 32, so a reload value is the code minus one.
	assign count_next = ratio_code - 5'h01;

	// The ratio is sampled only at reload, so a new code acts from the next count cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= 5'h00;
			ref_pulse <= 1'b0;
		end else if (hold) begin
			count_reg <= 5'h00;
			ref_pulse <= 1'b0;
		end else begin
			ref_pulse <= 1'b0;
			if (edge_en) begin
				if (count_reg == 5'h00) begin
					count_reg <= count_next;
					ref_pulse <= 1'b1;
				end else begin
					count_reg <= count_reg - 5'h01;
				end
			end
		end
	end

	// Without halving the level follows each pulse; with it a toggle gives a 50% duty clock.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_level <= 1'b0;
		end else if (hold) begin
			ref_level <= 1'b0;
		end else if (halve) begin
			ref_level <= edge_en && count_reg == 5'h00 ? ~ref_level : ref_level;
		end else begin
			ref_level <= edge_en && count_reg == 5'h00;
		end
	end

endmodule : rdfc_ref_counter

`default_nettype wire

/* File: hdl/rdfc_lock_detect.sv */
// Digital lock detector: measures every 32nd phase detector pulse against width thresholds.
// Assumes pfd_or is already synchronised to clk and ref_pulse marks each detector reference edge.
`default_nettype none

module rdfc_lock_detect #(
	parameter int REF_LOSS_CYC = rdfc_pkg::LD_REF_LOSS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pfd_or,
	input wire logic ref_pulse,
	input wire logic clear,
	input wire logic precise,
	input wire logic loss_mode,
	output logic locked
);
	import rdfc_pkg::*;

	logic pfd_prev_reg;
	logic [4:0] pulse_idx_reg;
	logic [7:0] width_reg;
	logic [2:0] good_reg;
	logic [$clog2(REF_LOSS_CYC + 1) - 1:0] idle_reg;
	logic fall;
	logic [7:0] thr;

	assign fall = pfd_prev_reg && !pfd_or;
	assign thr = precise ? 8'(LD_FINE_CYC) : 8'(LD_WIDE_CYC);

	// Width is counted in whole clock periods, so thresholds are resolved to 10 ns only.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pfd_prev_reg <= 1'b0;
			width_reg <= 8'h00;
			pulse_idx_reg <= 5'h00;
		end else begin
			pfd_prev_reg <= pfd_or;
			if (pfd_or) begin
				width_reg <= (width_reg == 8'hff) ? width_reg : width_reg + 8'h01;
			end else begin
				width_reg <= 8'h00;
			end
			if (fall) begin
				pulse_idx_reg <= pulse_idx_reg + 5'h01;
			end
		end
	end

	// Only the pulse whose index wraps to zero is judged, one in every 32.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			good_reg <= 3'h0;
			locked <= 1'b0;
		end else if (clear) begin
			good_reg <= 3'h0;
			locked <= 1'b0;
		end else if (loss_mode == 1'b0 && idle_reg == ($bits(idle_reg))'(REF_LOSS_CYC)) begin
			good_reg <= 3'h0;
			locked <= 1'b0;
		end else if (fall && pulse_idx_reg == 5'h00) begin
			if (width_reg > 8'(LD_UNLOCK_CYC)) begin
				locked <= 1'b0;
			end
			if (width_reg <= thr) begin
				good_reg <= (good_reg == 3'(LD_LOCK_COUNT)) ? good_reg : good_reg + 3'h1;
				if (good_reg == 3'(LD_LOCK_COUNT - 1)) begin
					locked <= 1'b1;
				end
			end else begin
				good_reg <= 3'h0;
			end
		end
	end

	// Reference watchdog: a missing reference drops lock when loss_mode is zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_reg <= '0;
		end else if (ref_pulse || clear) begin
			idle_reg <= '0;
		end else if (idle_reg != ($bits(idle_reg))'(REF_LOSS_CYC)) begin
			idle_reg <= idle_reg + 1'b1;
		end
	end

endmodule : rdfc_lock_detect

`default_nettype wire

/* File: hdl/rdfc_top.sv */
// Reference divider and function control block of a fractional-N synthesizer.
// Assumes one 100 MHz clock; serial, reference and detector pins are asynchronous and synchronised here.
//
// Overview of operation
// - Charge pump current code comes from reference divider word bits 27:24.
// - Bit 22 picks prescaler 4/5 or 8/9; host picks 8/9 above 8 GHz.
// - Bit 21 inserts a divide-by-two toggle after the reference counter.
// - Bit 20 doubles the reference before the five-bit counter.
// - Doubler off: falling edge only acts; doubler on: both edges act.
// - Five-bit field 19:15 divides the reference by 1 to 32.
// - Field 14:3 sets the ramp step clock divider.
// - Control bits 011 latch a word into the function register.
// - Bits 24:22 pick bleed current; bit 21 enables it.
// - Bit 16 zero: loss of lock shown even when reference disappears.
// - Bit 15 delays integer loading so integer and fraction land together.
// - Bit 14 zero resets the modulator on each integer/fraction write.
// - Bits 11:10 select the sweep waveform type.
// - Bit 9 enables phase keying; bit 8 enables frequency keying.
// - Lock detector measures every 32nd pulse of up OR down.
// - Lock after five measured pulses under 14 ns, or 6 ns with bit 7; here both limits are one 10 ns clock.
// - Lock holds until pulse over 22 ns, integer write, or power-down.
// - Bit 6 sets detector polarity: one positive, zero negative.
// - Bit 5 powers down: counters load, pump off, lock reset, port alive.
// - Control bits 010 latch a word into the reference divider register.
// - Function bit 4 three-states the charge pump.
// - Function bit 3 holds the synthesizer counters in reset.
`default_nettype none

module rdfc_top #(
	parameter int REF_LOSS_CYC = rdfc_pkg::LD_REF_LOSS_CYC,
	parameter int INT_DELAY_PFD = rdfc_pkg::INT_LOAD_DELAY_PFD
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_latch,
	input wire logic ref_in,
	input wire logic pfd_up,
	input wire logic pfd_dn,
	output rdfc_pkg::rdfc_cfg_t cfg,
	output logic [31:0] fractional_value_int_word,
	output logic pfd_ref_pulse,
	output logic pfd_ref_clk,
	output logic ramp_step_tick,
	output logic pump_tristate,
	output logic counter_hold,
	output logic lock_detect,
	output logic mod_reset_pulse,
	output logic int_load_pulse
);
	import rdfc_pkg::*;

	// Two-flop synchronisers for every pin.
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdat_sync_reg;
	logic [1:0] slat_sync_reg;
	logic [1:0] ref_sync_reg;
	logic [1:0] up_sync_reg;
	logic [1:0] dn_sync_reg;
	logic sclk_prev_reg;
	logic slat_prev_reg;
	logic ref_prev_reg;

	// Serial input register and latched words.
	logic [WORD_W-1:0] shift_reg;
	logic [31:0] reference_divider_word_reg;
	logic [31:0] function_control_word_reg;
	logic fractional_value_int_write;

	// Edge events of the synchronised pins.
	logic sclk_rise;
	logic latch_rise;
	logic ref_rise;
	logic ref_fall;
	logic ref_active;
	logic pfd_or_reg;

	// Counter internals.
	logic rc_pulse;
	logic rc_level;
	logic [11:0] step_cnt_reg;
	logic [11:0] step_cnt_next;
	logic [3:0] int_wait_reg;
	logic int_pending_reg;
	logic ld_locked;
	logic pd;

	assign pd = function_control_word_reg[FN_PD_BIT];

	// Pin synchronisers; only the second stage and the delayed copies feed logic.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_sync_reg <= 2'h0;
			sdat_sync_reg <= 2'h0;
			slat_sync_reg <= 2'h0;
			ref_sync_reg <= 2'h0;
			up_sync_reg <= 2'h0;
			dn_sync_reg <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], ser_clk};
			sdat_sync_reg <= {sdat_sync_reg[0], ser_data};
			slat_sync_reg <= {slat_sync_reg[0], ser_latch};
			ref_sync_reg <= {ref_sync_reg[0], ref_in};
			up_sync_reg <= {up_sync_reg[0], pfd_up};
			dn_sync_reg <= {dn_sync_reg[0], pfd_dn};
		end
	end

	// Delayed copies used to find edges of the synchronised pins.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_prev_reg <= 1'b0;
			slat_prev_reg <= 1'b0;
			ref_prev_reg <= 1'b0;
			pfd_or_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_sync_reg[1];
			slat_prev_reg <= slat_sync_reg[1];
			ref_prev_reg <= ref_sync_reg[1];
			pfd_or_reg <= up_sync_reg[1] | dn_sync_reg[1];
		end
	end

	assign sclk_rise = sclk_sync_reg[1] && !sclk_prev_reg;
	assign latch_rise = slat_sync_reg[1] && !slat_prev_reg;
	assign ref_rise = ref_sync_reg[1] && !ref_prev_reg;
	assign ref_fall = !ref_sync_reg[1] && ref_prev_reg;

	// The doubler is modelled by counting both reference edges instead of falling edges only.
	assign ref_active = reference_divider_word_reg[RD_DOUBLE_BIT] ? (ref_rise | ref_fall) : ref_fall;

	// Serial shift register, most significant bit first; it keeps running in power-down.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_reg <= '0;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[WORD_W-2:0], sdat_sync_reg[1]};
		end
	end

	// A latch edge decodes the control bits and loads the matching register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reference_divider_word_reg <= REF_DIV_RESET;
			function_control_word_reg <= FUNC_RESET;
			fractional_value_int_word <= FRACTIONAL_VALUE_INT_RESET;
		end else if (latch_rise) begin
			case (shift_reg[CTRL_W-1:0])
				CTRL_REF_DIV: begin
					reference_divider_word_reg <= shift_reg;
				end
				CTRL_FUNC: begin
					function_control_word_reg <= shift_reg;
				end
				CTRL_FRACTIONAL_VALUE_INT: begin
					fractional_value_int_word <= shift_reg;
				end
				default: begin
					reference_divider_word_reg <= reference_divider_word_reg;
				end
			endcase
		end
	end

	assign fractional_value_int_write = latch_rise && shift_reg[CTRL_W-1:0] == CTRL_FRACTIONAL_VALUE_INT;

	// Field decode; every field is a slice of a register, so the outputs are flop-driven.
	assign cfg.pump_current_level = reference_divider_word_reg[RD_CP_MSB:RD_CP_LSB];
	assign cfg.prescaler_89 = reference_divider_word_reg[RD_PRESC_BIT];
	assign cfg.reference_halver_enable = reference_divider_word_reg[RD_HALVE_BIT];
	assign cfg.doubler_en = reference_divider_word_reg[RD_DOUBLE_BIT];
	assign cfg.ref_count = reference_divider_word_reg[RD_RCNT_MSB:RD_RCNT_LSB];
	assign cfg.ramp_step_divider = reference_divider_word_reg[RD_STEP_MSB:RD_STEP_LSB];
	assign cfg.bleed_level = function_control_word_reg[FN_BLEED_MSB:FN_BLEED_LSB];
	assign cfg.bleed_en = function_control_word_reg[FN_BLEED_EN_BIT];
	assign cfg.loss_lock_mode = function_control_word_reg[FN_LOL_BIT];
	assign cfg.int_load_delay_en = function_control_word_reg[FN_NSEL_BIT];
	assign cfg.mod_keep = function_control_word_reg[FN_SDKEEP_BIT];
	assign cfg.ramp_mode = function_control_word_reg[FN_RAMP_MSB:FN_RAMP_LSB];
	assign cfg.psk_en = function_control_word_reg[FN_PSK_BIT];
	assign cfg.fsk_en = function_control_word_reg[FN_FSK_BIT];
	assign cfg.lock_precision_sel = function_control_word_reg[FN_LDP_BIT];
	assign cfg.detector_polarity = function_control_word_reg[FN_POL_BIT];
	assign cfg.power_down = pd;

	// Reference counter; power-down forces it to its load state.
	rdfc_ref_counter u_ref_counter (
		.clk(clk),
		.rst(rst),
		.edge_en(ref_active),
		.ratio_code(reference_divider_word_reg[RD_RCNT_MSB:RD_RCNT_LSB]),
		.halve(reference_divider_word_reg[RD_HALVE_BIT]),
		.hold(pd),
		.ref_pulse(rc_pulse),
		.ref_level(rc_level)
	);

	// Re-register the counter outputs so top outputs stay one flop from the pins.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pfd_ref_pulse <= 1'b0;
			pfd_ref_clk <= 1'b0;
		end else begin
			pfd_ref_pulse <= rc_pulse;
			pfd_ref_clk <= rc_level;
		end
	end

	// Ramp step divider counts detector reference pulses; a code of zero behaves as one.
	assign step_cnt_next = step_cnt_reg + 12'h001;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			step_cnt_reg <= 12'h000;
			ramp_step_tick <= 1'b0;
		end else if (pd) begin
			step_cnt_reg <= 12'h000;
			ramp_step_tick <= 1'b0;
		end else begin
			ramp_step_tick <= 1'b0;
			if (rc_pulse) begin
				if (step_cnt_next >= reference_divider_word_reg[RD_STEP_MSB:RD_STEP_LSB]) begin
					step_cnt_reg <= 12'h000;
					ramp_step_tick <= 1'b1;
				end else begin
					step_cnt_reg <= step_cnt_next;
				end
			end
		end
	end

	// Charge pump three-state and counter hold, both forced by power-down.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pump_tristate <= 1'b0;
			counter_hold <= 1'b0;
		end else begin
			pump_tristate <= function_control_word_reg[FN_CPTRI_BIT] | pd;
			counter_hold <= function_control_word_reg[FN_CRST_BIT] | pd;
		end
	end

	// Modulator reset pulse follows each integer/fraction write unless the keep bit is set.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mod_reset_pulse <= 1'b0;
		end else begin
			mod_reset_pulse <= fractional_value_int_write && !function_control_word_reg[FN_SDKEEP_BIT];
		end
	end

	// Integer load waits a few detector cycles when delayed loading is on, so it meets the fraction.
	// A second write during the wait restarts it; the last value written wins.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_pending_reg <= 1'b0;
			int_wait_reg <= 4'h0;
			int_load_pulse <= 1'b0;
		end else begin
			int_load_pulse <= 1'b0;
			if (fractional_value_int_write) begin
				if (function_control_word_reg[FN_NSEL_BIT]) begin
					int_pending_reg <= 1'b1;
					int_wait_reg <= 4'(INT_DELAY_PFD);
				end else begin
					int_pending_reg <= 1'b0;
					int_load_pulse <= 1'b1;
				end
			end else if (int_pending_reg && rc_pulse) begin
				if (int_wait_reg <= 4'h1) begin
					int_pending_reg <= 1'b0;
					int_load_pulse <= 1'b1;
				end else begin
					int_wait_reg <= int_wait_reg - 4'h1;
				end
			end
		end
	end

	// Lock detector; cleared by an integer/fraction write or by power-down.
	rdfc_lock_detect #(
		.REF_LOSS_CYC(REF_LOSS_CYC)
	) u_lock_detect (
		.clk(clk),
		.rst(rst),
		.pfd_or(pfd_or_reg),
		.ref_pulse(rc_pulse),
		.clear(fractional_value_int_write | pd),
		.precise(function_control_word_reg[FN_LDP_BIT]),
		.loss_mode(function_control_word_reg[FN_LOL_BIT]),
		.locked(ld_locked)
	);

	// Lock output is registered once more so it leaves the block from a flop.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_detect <= 1'b0;
		end else begin
			lock_detect <= ld_locked;
		end
	end

endmodule : rdfc_top

`default_nettype wire

/* File: tb/rdfc_properties.sv */
// Port checks for the reference divider and function control block.
// Assumes it is bound into rdfc_top; one clock, reset active high.
`default_nettype none
module rdfc_properties
	import rdfc_pkg::*;
#(
	parameter int REF_LOSS_CYC = LD_REF_LOSS_CYC,
	parameter int INT_DELAY_PFD = INT_LOAD_DELAY_PFD
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ser_latch,
	input wire logic pfd_up,
	input wire logic pfd_dn,
	input wire rdfc_pkg::rdfc_cfg_t cfg,
	input wire logic pfd_ref_pulse,
	input wire logic ramp_step_tick,
	input wire logic pump_tristate,
	input wire logic counter_hold,
	input wire logic lock_detect,
	input wire logic mod_reset_pulse,
	input wire logic int_load_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic or_q;
	logic [7:0] fall_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Pin-side count of detector pulse ends; it leads the synchronised view, so it can only err on the lenient side.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			or_q <= 1'b0;
			fall_cnt <= 8'h00;
		end else begin
			or_q <= pfd_up | pfd_dn;
			if (mod_reset_pulse || cfg.power_down)
				fall_cnt <= 8'h00;
			else if (or_q && !(pfd_up | pfd_dn) && fall_cnt != 8'hff)
				fall_cnt <= fall_cnt + 8'h01;
		end
	end
	pd_outputs_a: assert property (cfg.power_down [*3] |-> pump_tristate && counter_hold && !lock_detect)
		else $error("power-down outputs wrong");
	mod_pulse_a: assert property (mod_reset_pulse |-> !cfg.mod_keep ##1 !mod_reset_pulse)
		else $error("modulator reset pulse wrong");
	mod_lock_a: assert property (mod_reset_pulse |-> ##1 !lock_detect)
		else $error("lock kept after integer write");
	load_now_a: assert property (mod_reset_pulse && !cfg.int_load_delay_en |-> int_load_pulse)
		else $error("undelayed integer load missing");
	load_pulse_a: assert property (int_load_pulse |=> !int_load_pulse)
		else $error("integer load pulse too long");
	ref_pulse_a: assert property (pfd_ref_pulse |=> !pfd_ref_pulse)
		else $error("reference pulse too long");
	step_tick_a: assert property (ramp_step_tick |=> !ramp_step_tick)
		else $error("ramp step tick too long");
	lock_rise_a: assert property ($rose(lock_detect) |-> fall_cnt >= 8'd129 && !cfg.power_down)
		else $error("lock asserted too early");
	cfg_latch_a: assert property ($changed(cfg) |-> $past(ser_latch, 3))
		else $error("configuration changed without latch");
endmodule : rdfc_properties
`default_nettype wire

/* File: tb/rdfc_host.sv */
// Host model that writes words through the three-wire serial port.
// Assumes the bench calls send and that clk is the block's system clock.
`default_nettype none
module rdfc_host (
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_latch
);
	timeunit 1ns;
	timeprecision 1ps;
	// The serial clock stands low between words.
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_latch = 1'b0;
	end
	// Bit 31 goes first; four clocks per phase leave margin over the three the port needs.
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(negedge clk);
			ser_data = w[i];
			repeat (4) @(negedge clk);
			ser_clk = 1'b1;
			repeat (4) @(negedge clk);
			ser_clk = 1'b0;
		end
		// Data is not held after the word, so a stale bit can never pass for a valid one.
		ser_data = ~ser_data;
		repeat (2) @(negedge clk);
		ser_latch = 1'b1;
		repeat (5) @(negedge clk);
		ser_latch = 1'b0;
	endtask : send
endmodule : rdfc_host
`default_nettype wire

/* File: tb/rdfc_top_bench.sv */
// Self-checking bench for the reference divider and function control block.
// Assumes the host model and the property checker are compiled before it.
`default_nettype none
module rdfc_top_bench
	import rdfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Words keep reserved function bits at zero and bit 17 at one; integer values stay legal.
	localparam logic [31:0] REF_A = 32'h0a41_8012;
	localparam logic [31:0] REF_B = 32'h0711_8012;
	localparam logic [31:0] REF_C = 32'h0000_000a;
	localparam logic [31:0] REF_D = 32'h0020_800a;
	localparam logic [31:0] REF_E = 32'h0000_800a;
	localparam logic [31:0] F_ALL = 32'h0163_c3c3;
	localparam logic [31:0] F_RUN = 32'h0003_0003;
	localparam logic [31:0] F_RUN1 = 32'h0003_0083;
	localparam logic [31:0] F_PD = 32'h0003_0023;
	localparam logic [31:0] F_CPT = 32'h0003_0013;
	localparam logic [31:0] F_CRST = 32'h0003_000b;
	localparam logic [31:0] F_LOL0 = 32'h0002_0003;
	localparam logic [31:0] F_DELAY = 32'h0003_c003;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ref_in = 1'b1;
	logic pfd_up = 1'b0;
	logic pfd_dn = 1'b0;
	logic ser_clk, ser_data, ser_latch, pfd_ref_pulse, pfd_ref_clk, ramp_step_tick, pump_tristate;
	logic counter_hold, lock_detect, mod_reset_pulse, int_load_pulse, clk_q;
	rdfc_cfg_t cfg;
	logic [31:0] fractional_value_int_word;
	logic [31:0] rw = REF_DIV_RESET;
	logic [31:0] fw = FUNC_RESET;
	logic [31:0] xw = FRACTIONAL_VALUE_INT_RESET;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_ref, n_rise, n_tick, n_mod, n_load;
	always #5 clk = ~clk;
	rdfc_top #(.REF_LOSS_CYC(64), .INT_DELAY_PFD(4)) rdfc_top_inst (.clk, .rst, .ser_clk, .ser_data, .ser_latch,
		.ref_in, .pfd_up, .pfd_dn, .cfg, .fractional_value_int_word, .pfd_ref_pulse, .pfd_ref_clk, .ramp_step_tick,
		.pump_tristate, .counter_hold, .lock_detect, .mod_reset_pulse, .int_load_pulse);
	rdfc_host rdfc_host_inst (.clk, .ser_clk, .ser_data, .ser_latch);
	task automatic results();
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task automatic ckv(input logic [39:0] g, input logic [39:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : ckv
	task automatic ckn(input int g, input int e, input string m);
		ckv(40'(g), 40'(e), m);
	endtask : ckn
	function automatic rdfc_cfg_t expc(input logic [31:0] r, input logic [31:0] f);
		return {r[27:24], r[22:3], f[24:21], f[16:14], f[11:5]};
	endfunction : expc
	// Pulse counters and the hang guard; a run should end near 15200 cycles.
	always @(posedge clk) begin
		cyc++;
		n_ref += int'(pfd_ref_pulse === 1'b1);
		n_rise += int'(pfd_ref_clk === 1'b1 && clk_q !== 1'b1);
		clk_q = pfd_ref_clk;
		n_tick += int'(ramp_step_tick === 1'b1);
		n_mod += int'(mod_reset_pulse === 1'b1);
		n_load += int'(int_load_pulse === 1'b1);
		if (cyc == 40000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic clr();
		n_ref = 0;
		n_rise = 0;
		n_tick = 0;
		n_mod = 0;
		n_load = 0;
	endtask : clr
	// Writes one word and checks cfg, the fractional word, pump three-state and counter hold; other codes must change nothing.
	task automatic wr(input logic [31:0] w);
		rdfc_host_inst.send(w);
		if (w[2:0] == 3'b010)
			rw = w;
		else if (w[2:0] == 3'b011)
			fw = w;
		else if (w[2:0] == 3'b000)
			xw = w;
		repeat (8) @(negedge clk);
		ckv(cfg, expc(rw, fw), "cfg");
		ckv(fractional_value_int_word, xw, "fractional_value word");
		ckv(pump_tristate, fw[4] | fw[5], "pump");
		ckv(counter_hold, fw[3] | fw[5], "hold");
	endtask : wr
	task automatic refrun(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			ref_in = 1'b0;
			repeat (8) @(negedge clk);
			ref_in = 1'b1;
			repeat (7) @(negedge clk);
		end
		repeat (6) @(negedge clk);
	endtask : refrun
	task automatic pfd(input int n, input int w);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			pfd_up = ~i[0];
			pfd_dn = i[0];
			repeat (w) @(negedge clk);
			pfd_up = 1'b0;
			pfd_dn = 1'b0;
			repeat (3) @(negedge clk);
		end
		repeat (8) @(negedge clk);
	endtask : pfd
	// Power-down parks the reference counter at zero, so pulse counts are exact afterwards.
	task automatic rt(input logic [31:0] r, input int n, input int er, input int ec, input int et);
		wr(r);
		wr(F_PD);
		wr(F_RUN);
		clr();
		refrun(n);
		if (er >= 0) begin
			ckn(n_ref, er, "ref pulses");
			ckn(n_tick, et, "ramp ticks");
		end
		ckn(n_rise, ec, "ref clock");
	endtask : rt
	// Main sequence: fields, refused codes, reference path, delayed load, then lock detect.
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		ckv({cfg, pump_tristate, counter_hold}, 40'h00_0000_0000, "reset");
		ckv(lock_detect, 1'b0, "reset lock");
		wr(REF_A);
		for (int i = 0; i < 4; i++)
			wr(F_ALL | (32'(i) << 10));
		for (int c = 4; c < 8; c++)
			wr({29'h1fff_ffff, 3'(c)});
		wr(F_CPT);
		wr(F_CRST);
		rt(REF_A, 6, 2, 2, 1);
		rt(REF_B, 6, 4, 4, 2);
		rt(REF_C, 32, 1, 1, 1);
		rt(REF_D, 8, 8, 4, 8);
		rt(REF_E, 5, 5, 5, 5);
		wr(F_DELAY);
		clr();
		wr(32'h0040_0008);
		ckn(n_mod, 0, "kept modulator");
		refrun(3);
		ckn(n_load, 0, "early load");
		refrun(2);
		ckn(n_load, 1, "late load");
		wr(F_RUN);
		pfd(128, 1);
		ckv(lock_detect, 1'b0, "early lock");
		pfd(32, 1);
		ckv(lock_detect, 1'b1, "lock");
		pfd(32, 3);
		ckv(lock_detect, 1'b0, "wide unlock");
		wr(F_RUN1);
		pfd(160, 1);
		ckv(lock_detect, 1'b1, "fine lock");
		clr();
		wr(32'h1234_5678);
		ckv(lock_detect, 1'b0, "write unlock");
		ckn(n_mod, 1, "modulator reset");
		ckn(n_load, 1, "integer load");
		pfd(160, 1);
		ckv(lock_detect, 1'b1, "relock");
		wr(F_PD);
		ckv(lock_detect, 1'b0, "power-down unlock");
		wr(REF_B);
		wr(F_RUN);
		pfd(160, 1);
		ckv(lock_detect, 1'b1, "lock after wake");
		wr(F_LOL0);
		repeat (100) @(negedge clk);
		ckv(lock_detect, 1'b0, "reference loss");
		results();
	end
endmodule : rdfc_top_bench
bind rdfc_top rdfc_properties #(.REF_LOSS_CYC(REF_LOSS_CYC), .INT_DELAY_PFD(INT_DELAY_PFD)) rdfc_properties_inst (
	.clk, .rst, .ser_latch, .pfd_up, .pfd_dn, .cfg, .pfd_ref_pulse, .ramp_step_tick, .pump_tristate,
	.counter_hold, .lock_detect, .mod_reset_pulse, .int_load_pulse);
`default_nettype wire
